//--- hdl/msev_event_select.sv
// Implementation choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Functional notes
// - codes e3/e4 count ingress credit starvation cycles
// - starvation counts only in injection starvation mode
// - credited plus uncredited bits OR, once per cycle
// - fabric snoop counts as acknowledge type
// - code e1 counts ingress queue allocations
// - code e0 reports masked ingress occupancy
// - allocation and occupancy sum both bits
// - bits 1,2,3 select ack, data, snoop
// - bits 0,4,6 select request and credited data
// - both-bit request or data values accepted
// - bit 7 fabric snoop or core ack
// - occupancy credited data uses bit 5
// - codes d0/d1 agent0 request crossing stalls
// - codes d2/d3 agent1 request crossing stalls
// - codes d4/d5 agent0 data crossing stalls
// - code d6 agent1 data crossing stalls
// - low group bit n enables crossing point n
// - high group bits 0-2 mean points 8-10
// - high group unused, never increments
// - qualifier taken from selection bits 15:8
module msev_event_select
  import msev_pkg::*;
#(
  parameter int OCC_W = 6
)(
  // clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // axi4-lite write address
  input  wire logic [MSEV_ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic [2:0]              s_axi_awprot,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  // axi4-lite read address
  input  wire logic [MSEV_ADDR_W-1:0]  s_axi_araddr,
  input  wire logic [2:0]              s_axi_arprot,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // ingress queue status
  input  wire logic                    starve_mode,
  input  wire logic [7:0]              starve_cond,
  input  wire logic [7:0]              alloc_pulse,
  input  wire logic [8*OCC_W-1:0]      occ_count,
  // egress crossing point stalls, points 0 to 7
  input  wire logic [7:0]              stall_req_ag0,
  input  wire logic [7:0]              stall_req_ag1,
  input  wire logic [7:0]              stall_data_ag0,
  input  wire logic [7:0]              stall_data_ag1,
  // counter side
  output logic [OCC_W+2:0]             evt_inc,
  output logic                         evt_active
);

  localparam int SUM_W = OCC_W + 3;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic msev_cls_t cls_of(input logic [7:0] code);
    msev_cls_t c;
    c = MSEV_CLS_NONE;
    case (code)
      MSEV_STARVE_CODE, MSEV_STARVE_B_CODE: c = MSEV_CLS_STARVE;
      MSEV_ALLOC_CODE:                      c = MSEV_CLS_ALLOC;
      MSEV_OCC_CODE:                        c = MSEV_CLS_OCC;
      MSEV_REQ_AG0_LO, MSEV_REQ_AG1_LO,
      MSEV_DAT_AG0_LO, MSEV_DAT_AG1_LO:     c = MSEV_CLS_EGRESS;
      default:                              c = MSEV_CLS_NONE;
    endcase
    return c;
  endfunction

  function automatic logic [3:0] ones(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++)
    begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // egress source per event code; the high group has no inputs here,
  // so its codes fall to the default and never count
  function automatic logic [7:0] stall_src(input logic [7:0] c,
                                           input logic [7:0] r0,
                                           input logic [7:0] r1,
                                           input logic [7:0] d0,
                                           input logic [7:0] d1);
    logic [7:0] v;
    v = 8'h00;
    case (c)
      MSEV_REQ_AG0_LO: v = r0;
      MSEV_REQ_AG1_LO: v = r1;
      MSEV_DAT_AG0_LO: v = d0;
      MSEV_DAT_AG1_LO: v = d1;
      default:         v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [31:0]            sel_q;
  logic                   aw_full_q;
  logic                   w_full_q;
  logic [MSEV_ADDR_W-1:0] awaddr_q;
  logic [31:0]            wdata_q;
  logic [3:0]             wstrb_q;
  logic                   awready_q;
  logic                   wready_q;
  logic                   bvalid_q;
  logic [1:0]             bresp_q;
  logic                   arready_q;
  logic                   rvalid_q;
  logic [31:0]            rdata_q;
  logic [1:0]             rresp_q;
  logic [SUM_W-1:0]       inc_q;
  logic                   active_q;

  // ----------------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------------
  wire logic aw_take   = s_axi_awvalid & awready_q;
  wire logic w_take    = s_axi_wvalid & wready_q;
  // address and data may arrive in either order; commit once both are held
  wire logic wr_fire   = aw_full_q & w_full_q & ~bvalid_q;
  wire logic aw_full_d = (aw_full_q | aw_take) & ~wr_fire;
  wire logic w_full_d  = (w_full_q | w_take) & ~wr_fire;
  wire logic bvalid_d  = wr_fire | (bvalid_q & ~s_axi_bready);
  wire logic wr_sel    = (awaddr_q == MSEV_SEL_OFS);
  wire logic wr_stat   = (awaddr_q == MSEV_STAT_OFS);

  wire logic [31:0] strb_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                                 {8{wstrb_q[1]}}, {8{wstrb_q[0]}}} & MSEV_SEL_WMASK;
  wire logic [31:0] sel_d = (sel_q & ~strb_mask) | (wdata_q & strb_mask);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= MSEV_RESP_OKAY;
      sel_q     <= MSEV_SEL_RST;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      // both readies stay low while a response is owed: one write in flight
      awready_q <= ~aw_full_d & ~bvalid_d;
      wready_q  <= ~w_full_d & ~bvalid_d;
      bvalid_q  <= bvalid_d;
      if (aw_take)
      begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take)
      begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        // status is read-only; writing it is harmless and answered okay
        bresp_q <= (wr_sel | wr_stat) ? MSEV_RESP_OKAY : MSEV_RESP_SLVERR;
        if (wr_sel)
        begin
          sel_q <= sel_d;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------------
  wire logic ar_take  = s_axi_arvalid & arready_q;
  wire logic rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);

  // status word: live mode and active flag sit above the increment field
  wire logic [31:0] stat_inc    = 32'(inc_q) << MSEV_STAT_INC_LSB;
  wire logic [31:0] stat_starve = 32'(starve_mode) << MSEV_STAT_STARVE_BIT;
  wire logic [31:0] stat_active = 32'(active_q) << MSEV_STAT_ACTIVE_BIT;
  wire logic [31:0] stat_word   = stat_inc | stat_starve | stat_active;
  wire logic rd_sel  = (s_axi_araddr == MSEV_SEL_OFS);
  wire logic rd_stat = (s_axi_araddr == MSEV_STAT_OFS);
  wire logic [31:0] rd_word = rd_sel ? (sel_q & MSEV_SEL_WMASK) :
                              rd_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= MSEV_RESP_OKAY;
    end
    else
    begin
      // one read in flight: the address waits until the data is taken
      arready_q <= ~rvalid_d;
      rvalid_q  <= rvalid_d;
      if (ar_take)
      begin
        rdata_q <= rd_word;
        rresp_q <= (rd_sel | rd_stat) ? MSEV_RESP_OKAY : MSEV_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // event qualification
  // ----------------------------------------------------------------------
  wire logic [7:0] code = sel_q[MSEV_CODE_MSB:MSEV_CODE_LSB];
  wire logic [7:0] qual = sel_q[MSEV_QUAL_MSB:MSEV_QUAL_LSB];
  wire msev_cls_t  cls  = cls_of(code);
  wire logic       enab = sel_q[MSEV_EN_BIT];

  // ingress enables, indexed like the status inputs; bit 5 names no
  // ingress channel outside occupancy, so it is dropped there
  wire logic [7:0] ing_en;
  assign ing_en[MSEV_CH_REQ_UNCRD] = qual[MSEV_CH_REQ_UNCRD];
  assign ing_en[MSEV_CH_ACK]       = qual[MSEV_CH_ACK];
  assign ing_en[MSEV_CH_DAT_UNCRD] = qual[MSEV_CH_DAT_UNCRD];
  assign ing_en[MSEV_CH_SNOOP]     = qual[MSEV_CH_SNOOP];
  assign ing_en[MSEV_CH_REQ_CRD]   = qual[MSEV_CH_REQ_CRD];
  assign ing_en[MSEV_OCC_DAT_BIT]  = 1'b0;
  assign ing_en[MSEV_CH_DAT_CRD]   = qual[MSEV_CH_DAT_CRD];
  assign ing_en[MSEV_CH_BIT7]      = qual[MSEV_CH_BIT7];

  // occupancy moves the credited data channel onto bit 5 and ignores bit 6
  wire logic [7:0] occ_en;
  assign occ_en[MSEV_CH_REQ_UNCRD] = qual[MSEV_CH_REQ_UNCRD];
  assign occ_en[MSEV_CH_ACK]       = qual[MSEV_CH_ACK];
  assign occ_en[MSEV_CH_DAT_UNCRD] = qual[MSEV_CH_DAT_UNCRD];
  assign occ_en[MSEV_CH_SNOOP]     = qual[MSEV_CH_SNOOP];
  assign occ_en[MSEV_CH_REQ_CRD]   = qual[MSEV_CH_REQ_CRD];
  assign occ_en[MSEV_OCC_DAT_BIT]  = 1'b0;
  assign occ_en[MSEV_CH_DAT_CRD]   = qual[MSEV_OCC_DAT_BIT];
  assign occ_en[MSEV_CH_BIT7]      = qual[MSEV_CH_BIT7];

  // fabric snoop sits on starve_cond[7] and is folded with ack by the OR;
  // software keeps to one ring type, so the OR is the per-type OR
  wire logic starve_hit = starve_mode & |(starve_cond & ing_en);
  wire logic [3:0] alloc_n = ones(alloc_pulse & ing_en);

  // running sum over the eight slices; the width holds eight full queues
  wire logic [8:0][SUM_W-1:0] occ_part;
  assign occ_part[0] = '0;
  for (genvar i = 0; i < 8; i++)
  begin : g_occ
    wire logic [SUM_W-1:0] slice_v;
    wire logic [SUM_W-1:0] add_v;
    assign slice_v       = SUM_W'(occ_count[i*OCC_W +: OCC_W]);
    assign add_v         = occ_en[i] ? slice_v : '0;
    assign occ_part[i+1] = occ_part[i] + add_v;
  end
  wire logic [SUM_W-1:0] occ_sum = occ_part[8];

  // ----------------------------------------------------------------------
  // egress events
  // ----------------------------------------------------------------------
  // low group only: points 8 to 10 are not built on this variant
  wire logic [7:0] stall_vec = stall_src(code, stall_req_ag0, stall_req_ag1,
                                         stall_data_ag0, stall_data_ag1);
  wire logic [7:0] stall_pt;
  for (genvar n = 0; n < 8; n++)
  begin : g_point
    assign stall_pt[n] = stall_vec[n] & qual[n];
  end
  wire logic stall_hit = |stall_pt;

  // ----------------------------------------------------------------------
  // increment selection
  // ----------------------------------------------------------------------
  wire logic [SUM_W-1:0] starve_inc = SUM_W'(starve_hit);
  wire logic [SUM_W-1:0] alloc_inc  = SUM_W'(alloc_n);
  wire logic [SUM_W-1:0] stall_inc  = SUM_W'(stall_hit);

  wire logic [SUM_W-1:0] inc_d =
    !enab                    ? '0 :
    (cls == MSEV_CLS_STARVE) ? starve_inc :
    (cls == MSEV_CLS_ALLOC)  ? alloc_inc :
    (cls == MSEV_CLS_OCC)    ? occ_sum :
    (cls == MSEV_CLS_EGRESS) ? stall_inc :
    '0;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      inc_q    <= '0;
      active_q <= 1'b0;
    end
    else
    begin
      inc_q    <= inc_d;
      active_q <= enab & (cls != MSEV_CLS_NONE);
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign evt_inc       = inc_q;
  assign evt_active    = active_q;

endmodule // msev_event_select

//--- hdl/msev_pkg.sv
// ----------------------------------------------------------------------
// event selection constants
// ----------------------------------------------------------------------
package msev_pkg;

  // register map, byte addresses
  localparam logic [11:0] MSEV_SEL_OFS  = 12'h000;
  localparam logic [11:0] MSEV_STAT_OFS = 12'h004;
  localparam int          MSEV_ADDR_W   = 12;

  // selection word fields
  localparam int MSEV_CODE_LSB = 0;
  localparam int MSEV_CODE_MSB = 7;
  localparam int MSEV_QUAL_LSB = 8;
  localparam int MSEV_QUAL_MSB = 15;
  localparam int MSEV_EN_BIT   = 22;
  localparam logic [31:0] MSEV_SEL_RST   = 32'h0000_0000;
  localparam logic [31:0] MSEV_SEL_WMASK = 32'h0040_FFFF;

  // status word fields
  localparam int MSEV_STAT_INC_LSB    = 0;
  localparam int MSEV_STAT_STARVE_BIT = 16;
  localparam int MSEV_STAT_ACTIVE_BIT = 17;

  // event codes
  localparam logic [7:0] MSEV_OCC_CODE      = 8'hE0;
  localparam logic [7:0] MSEV_ALLOC_CODE    = 8'hE1;
  localparam logic [7:0] MSEV_STARVE_CODE   = 8'hE3;
  localparam logic [7:0] MSEV_STARVE_B_CODE = 8'hE4;
  localparam logic [7:0] MSEV_REQ_AG0_LO    = 8'hD0;
  localparam logic [7:0] MSEV_REQ_AG0_HI    = 8'hD1;
  localparam logic [7:0] MSEV_REQ_AG1_LO    = 8'hD2;
  localparam logic [7:0] MSEV_REQ_AG1_HI    = 8'hD3;
  localparam logic [7:0] MSEV_DAT_AG0_LO    = 8'hD4;
  localparam logic [7:0] MSEV_DAT_AG0_HI    = 8'hD5;
  localparam logic [7:0] MSEV_DAT_AG1_LO    = 8'hD6;

  // ingress channel index, equal to the qualifier bit that selects it, except occupancy, where bit 5 selects credited data
  localparam int MSEV_CH_REQ_UNCRD = 0;
  localparam int MSEV_CH_ACK       = 1;
  localparam int MSEV_CH_DAT_UNCRD = 2;
  localparam int MSEV_CH_SNOOP     = 3;
  localparam int MSEV_CH_REQ_CRD   = 4;
  localparam int MSEV_OCC_DAT_BIT  = 5;
  localparam int MSEV_CH_DAT_CRD   = 6;
  localparam int MSEV_CH_BIT7      = 7;

  // axi responses
  localparam logic [1:0] MSEV_RESP_OKAY   = 2'h0;
  localparam logic [1:0] MSEV_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    MSEV_CLS_NONE   = 3'h0,
    MSEV_CLS_STARVE = 3'h1,
    MSEV_CLS_ALLOC  = 3'h3,
    MSEV_CLS_OCC    = 3'h2,
    MSEV_CLS_EGRESS = 3'h6
  } msev_cls_t;

endpackage

//--- tb/msev_event_select_assertions.sv
`timescale 1ns/1ps
module msev_event_select_assertions
  import msev_pkg::*;
#(
  parameter int OCC_W = 6
)(
  // clock and reset
  input wire logic                   aclk,
  input wire logic                   aresetn,
  // write channels
  input wire logic [MSEV_ADDR_W-1:0] s_axi_awaddr,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic [31:0]            s_axi_wdata,
  input wire logic [3:0]             s_axi_wstrb,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  // queue status
  input wire logic                   starve_mode,
  input wire logic [7:0]             starve_cond,
  input wire logic [7:0]             alloc_pulse,
  input wire logic [8*OCC_W-1:0]     occ_count,
  input wire logic [7:0]             stall_req_ag0,
  input wire logic [7:0]             stall_req_ag1,
  input wire logic [7:0]             stall_data_ag0,
  input wire logic [7:0]             stall_data_ag1,
  // counter side
  input wire logic [OCC_W+2:0]       evt_inc,
  input wire logic                   evt_active
);
  // ----------------------------------------
  // selection shadow
  // ----------------------------------------
  // rebuilt from the write channel, so a new selection is expected from the
  // first edge after the response appears
  logic [11:0] wa_q;
  logic [31:0] wd_q;
  logic [31:0] sh_q;
  logic [3:0]  ws_q;
  logic        bv_q;
  wire  [7:0]  cd  = sh_q[7:0];
  wire  [7:0]  q   = sh_q[15:8];
  wire         act = sh_q[MSEV_EN_BIT]
                     && cd inside {8'hE0, 8'hE1, 8'hE3, 8'hE4, 8'hD0, 8'hD2, 8'hD4, 8'hD6};

  always_ff @(posedge aclk)
  begin
    bv_q <= s_axi_bvalid;
    if (s_axi_awvalid && s_axi_awready)
      wa_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready)
    begin
      wd_q <= s_axi_wdata;
      ws_q <= s_axi_wstrb;
    end
    if (!aresetn)
      sh_q <= MSEV_SEL_RST;
    else if (s_axi_bvalid && !bv_q && wa_q == MSEV_SEL_OFS)
      for (int b = 0; b < 4; b++)
        if (ws_q[b])
          sh_q[8*b +: 8] <= wd_q[8*b +: 8] & MSEV_SEL_WMASK[8*b +: 8];
  end

  // bit 6 never adds to occupancy, bit 5 stands for the credited data slice
  function automatic logic [OCC_W+2:0] occ_f(logic [7:0] m, logic [8*OCC_W-1:0] o);
    occ_f = '0;
    for (int i = 0; i < 8; i++)
      if (m[i] && i != 6)
        occ_f += o[(i == 5 ? 6 : i)*OCC_W +: OCC_W];
  endfunction

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_STARVE: assert property (act && cd inside {8'hE3, 8'hE4} |-> evt_inc ==
    ($past(starve_mode) && |($past(starve_cond) & q & 8'hDF)))
    else $error("starvation increment wrong");
  AST_STARVE_MODE: assert property (!starve_mode ##1 act && cd inside {8'hE3, 8'hE4}
    |-> evt_inc == '0) else $error("starvation counted outside starvation mode");
  AST_ALLOC: assert property (act && cd == 8'hE1
    |-> evt_inc == $countones($past(alloc_pulse) & q & 8'hDF)) else $error("allocation sum wrong");
  AST_OCC: assert property (act && cd == 8'hE0
    |-> evt_inc == occ_f(q, $past(occ_count))) else $error("occupancy sum wrong");
  AST_EGRESS: assert property (act && cd[7:4] == 4'hD |-> evt_inc ==
    |(q & (cd == 8'hD0 ? $past(stall_req_ag0) : cd == 8'hD2 ? $past(stall_req_ag1)
      : cd == 8'hD4 ? $past(stall_data_ag0) : $past(stall_data_ag1))))
    else $error("crossing stall increment wrong");
  AST_HIGH: assert property (sh_q[MSEV_EN_BIT] && cd inside {8'hD1, 8'hD3, 8'hD5}
    |-> evt_inc == '0 && !evt_active) else $error("high group counted");
  AST_UNDEF: assert property (!act |-> evt_inc == '0) else $error("undefined selection counted");
  AST_ACTIVE: assert property (evt_active == act) else $error("active flag wrong");
  AST_ONCE: assert property (act && !(cd inside {8'hE0, 8'hE1}) |-> evt_inc <= 1)
    else $error("more than one count per cycle");
endmodule // msev_event_select_assertions

bind msev_event_select msev_event_select_assertions #(.OCC_W(OCC_W)) i_msev_event_select_assertions (.*);

//--- tb/msev_queue_model.sv
`timescale 1ns/1ps
module msev_queue_model
#(
  parameter int OCC_W = 6
)(
  // clock
  input wire logic          aclk,
  // queue status toward the block
  output logic              starve_mode,
  output logic [7:0]        starve_cond,
  output logic [7:0]        alloc_pulse,
  output logic [8*OCC_W-1:0] occ_count,
  output logic [7:0]        stall_req_ag0,
  output logic [7:0]        stall_req_ag1,
  output logic [7:0]        stall_data_ag0,
  output logic [7:0]        stall_data_ag1
);
  initial
  begin
    {starve_mode, starve_cond, alloc_pulse, occ_count} = '0;
    {stall_req_ag0, stall_req_ag1, stall_data_ag0, stall_data_ag1} = '0;
  end

  // one cycle of status; allocations are single-cycle pulses
  task automatic drive(input logic m, input logic [7:0] sc, ap,
                       input logic [8*OCC_W-1:0] oc, input logic [7:0] r0, r1, d0, d1);
    @(posedge aclk);
    starve_mode    <= m;
    starve_cond    <= sc;
    alloc_pulse    <= ap;
    occ_count      <= oc;
    stall_req_ag0  <= r0;
    stall_req_ag1  <= r1;
    stall_data_ag0 <= d0;
    stall_data_ag1 <= d1;
    @(posedge aclk);
    alloc_pulse <= 8'h00;
    #1;
  endtask
endmodule // msev_queue_model

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import msev_pkg::*;
;
  logic        aclk;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        starve_mode, evt_active;
  logic [7:0]  starve_cond, alloc_pulse, stall_req_ag0, stall_req_ag1, stall_data_ag0;
  logic [7:0]  stall_data_ag1;
  logic [47:0] occ_count;
  logic [8:0]  evt_inc;
  int          n_fail = 0;
  int          checked = 0;
  localparam logic [47:0] OCC = {6'h8, 6'h7, 6'h6, 6'h5, 6'h4, 6'h3, 6'h2, 6'h1};
  // one ring type per qualifier only
  logic [7:0]  ms [12] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80,
                           8'h11, 8'h44, 8'h24, 8'h82};

  msev_event_select i_msev_event_select (.*);
  msev_queue_model i_msev_queue_model (.*);

  initial
  begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      n_fail++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk(s_axi_bresp, r);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk(s_axi_rresp, r);
  endtask

  task automatic sel(input logic [7:0] c, input logic [7:0] m);
    wr(MSEV_SEL_OFS, 32'h0040_0000 | {m, c}, 4'hF, MSEV_RESP_OKAY);
  endtask

  task automatic dr(input logic m, input logic [7:0] sc, ap, r0, r1, d0, d1);
    i_msev_queue_model.drive(m, sc, ap, OCC, r0, r1, d0, d1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [31:0] d;
    rd(MSEV_SEL_OFS, d, MSEV_RESP_OKAY);
    chk(d, MSEV_SEL_RST);
    wr(MSEV_SEL_OFS, 32'hFFFF_FFFF, 4'hF, MSEV_RESP_OKAY);
    rd(MSEV_SEL_OFS, d, MSEV_RESP_OKAY);
    chk(d, MSEV_SEL_WMASK);
    wr(MSEV_SEL_OFS, 32'h0000_1200, 4'h2, MSEV_RESP_OKAY);
    rd(MSEV_SEL_OFS, d, MSEV_RESP_OKAY);
    chk(d, 32'h0040_12FF);
    wr(MSEV_STAT_OFS, 32'hFFFF_FFFF, 4'hF, MSEV_RESP_OKAY);
    rd(MSEV_STAT_OFS, d, MSEV_RESP_OKAY);
    chk(d[17:16], 2'h0);
    wr(12'h010, 32'hFFFF_FFFF, 4'hF, MSEV_RESP_SLVERR);
    rd(12'h010, d, MSEV_RESP_SLVERR);
    chk(d, 32'h0);
  endtask

  task automatic t_starve();
    foreach (ms[i])
      for (int c = 0; c < 2; c++)
      begin
        sel(c ? 8'hE4 : 8'hE3, ms[i]);
        dr(1'b1, ms[i], 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
        chk(evt_inc, (ms[i] & 8'hDF) != 8'h00);
        chk(evt_active, 1'b1);
        dr(1'b0, ms[i], 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
        chk(evt_inc, 0);
        dr(1'b1, ~ms[i], 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
        chk(evt_inc, 0);
      end
  endtask

  task automatic t_alloc();
    foreach (ms[i])
    begin
      sel(8'hE1, ms[i]);
      dr(1'b1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
      chk(evt_inc, $countones(ms[i] & 8'hDF));
      dr(1'b1, 8'hFF, ~ms[i], 8'hFF, 8'hFF, 8'hFF, 8'hFF);
      chk(evt_inc, 0);
    end
  endtask

  task automatic t_occ();
    int e;
    foreach (ms[i])
    begin
      e = 0;
      for (int b = 0; b < 8; b++)
        if (ms[i][b] && b != 6)
          e += (b == 5) ? 7 : b + 1;
      sel(8'hE0, ms[i]);
      dr(1'b1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
      chk(evt_inc, e);
    end
  endtask

  task automatic t_egress();
    logic [7:0] t;
    for (int k = 0; k < 4; k++)
      for (int n = 0; n < 8; n++)
      begin
        t = 8'h01 << n;
        sel(8'hD0 + 8'(2 * k), t);
        dr(1'b1, 8'hFF, 8'hFF, k == 0 ? t : 8'h00, k == 1 ? t : 8'h00,
           k == 2 ? t : 8'h00, k == 3 ? t : 8'h00);
        chk(evt_inc, 1);
        t = ~t;
        dr(1'b1, 8'hFF, 8'hFF, k == 0 ? t : 8'hFF, k == 1 ? t : 8'hFF,
           k == 2 ? t : 8'hFF, k == 3 ? t : 8'hFF);
        chk(evt_inc, 0);
      end
  endtask

  task automatic t_none();
    logic [31:0] w [8] = '{32'h0040_FFD1, 32'h0040_FFD3, 32'h0040_FFD5, 32'h0040_FFD7,
                          32'h0040_FFE2, 32'h0040_FFE5, 32'h0040_FF00, 32'h0000_FFE3};
    foreach (w[i])
    begin
      wr(MSEV_SEL_OFS, w[i], 4'hF, MSEV_RESP_OKAY);
      dr(1'b1, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
      chk(evt_inc, 0);
      chk(evt_active, 1'b0);
    end
  endtask

  task automatic t_stat();
    logic [31:0] d;
    sel(MSEV_STARVE_CODE, 8'h01);
    dr(1'b1, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    rd(MSEV_STAT_OFS, d, MSEV_RESP_OKAY);
    chk(d, (32'h1 << MSEV_STAT_STARVE_BIT) | (32'h1 << MSEV_STAT_ACTIVE_BIT) | 32'h1);
    dr(1'b0, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    rd(MSEV_STAT_OFS, d, MSEV_RESP_OKAY);
    chk(d, 32'h1 << MSEV_STAT_ACTIVE_BIT);
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_starve();
    t_alloc();
    t_occ();
    t_egress();
    t_none();
    t_stat();
    give_verdict();
  end

  // the whole run needs under a thousand cycles
  initial
  begin
    #(50 * 20000);
    n_fail++;
    give_verdict();
  end
endmodule // tb_top
